// [shared/cms_defs.svh]
// constants of the configuration status mapper: offsets, fields, resets
// assumes inclusion by bare name from the package; the rtl files use its macros without including it
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// ============================================================
// register offsets (byte addresses)
`define CMS_ADDR_W        8
`define CMS_CTRL_OFS      8'h00
`define CMS_STAT_OFS      8'h04
`define CMS_ISR_OFS       8'h08
`define CMS_IMR_OFS       8'h0c
`define CMS_VEC0_OFS      8'h10
`define CMS_VEC1_OFS      8'h14
`define CMS_VEC2_OFS      8'h18
`define CMS_VEC3_OFS      8'h1c

// ============================================================
// register fields and reset values
`define CMS_CTRL_EN_BIT   0
`define CMS_CTRL_CLR_BIT  1
`define CMS_CTRL_RST      32'h0000_0001
`define CMS_IMR_RST       3'h0
`define CMS_IRQ_W         3
`define CMS_IRQ_UPD_BIT   0
`define CMS_IRQ_ERR_BIT   1
`define CMS_IRQ_DLL_BIT   2
`define CMS_RESP_OKAY     2'h0
`define CMS_RESP_SLVERR   2'h2

// ============================================================
// status vector layout
`define CMS_VEC_W         123
`define CMS_F0_W          53
`define CMS_FN_W          10
`define CMS_FN_BASE       53
`define CMS_FN_COUNT      7
`define CMS_F0_DEV_MSB    52
`define CMS_F0_DEV_LSB    49
`define CMS_F0_DLL_BIT    48
`define CMS_F0_CMD_BIT    47
`define CMS_F0_LINK_MSB   46
`define CMS_F0_LINK_LSB   31
`define CMS_LINK_UNDEF    10
`define CMS_F0_DEEMP_BIT  30
`define CMS_F0_PRI_MSB    29
`define CMS_F0_PRI_LSB    25
`define CMS_F0_MPE_BIT    24
`define CMS_F0_ROOT_MSB   23
`define CMS_F0_ROOT_LSB   6
`define CMS_F0_SEC_MSB    5
`define CMS_F0_SEC_LSB    1
`define CMS_F0_MPE2_BIT   0

// ============================================================
// timing: at most one strobe toggle per this many core clocks
`define CMS_UPDATE_PERIOD 8
`define CMS_CNT_W         3

`endif

// [shared/cms_pkg.sv]
// types of the configuration status mapper
// assumes cms_defs.svh is on the include path
`include "cms_defs.svh"

package cms_pkg;

	// ============================================================
	// function 0 configuration fields
	typedef struct packed {
		logic [3:0]  devStatus;
		logic        dllStateChanged;
		logic        cmdCompleted;
		logic [15:0] linkStatus;
		logic        deEmphasis;
		logic [4:0]  primaryErr;
		logic        masterParityErr;
		logic [17:0] rootStatus;
		logic [4:0]  secondaryErr;
	} cms_func0_t;

	// ============================================================
	// functions 1 to 7 configuration fields
	typedef struct packed {
		logic [3:0] devStatus;
		logic [4:0] linkStatusHigh;
		logic       masterParityErr;
	} cms_funcn_t;

	// ============================================================
	// register access between bus slave and register file
	typedef struct packed {
		logic [`CMS_ADDR_W-1:0] addr;
		logic [31:0]            data;
		logic [3:0]             strb;
	} cms_regwr_t;

endpackage

// [rtl/cms_axil_slave.sv]
// axi4-lite slave front end: one write and one read under way at a time
// assumes the register file decodes the address in the same cycle
module cms_axil_slave
	import cms_pkg::*;
(
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	// axi4-lite
	input  wire logic [`CMS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output      logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output      logic                   s_axi_wready,
	output      logic [1:0]             s_axi_bresp,
	output      logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`CMS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output      logic                   s_axi_arready,
	output      logic [31:0]            s_axi_rdata,
	output      logic [1:0]             s_axi_rresp,
	output      logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// register file side
	output      logic                   regWrite,
	output      cms_regwr_t             regWr,
	input  wire logic                   regWrOk,
	output      logic [`CMS_ADDR_W-1:0] regRaddr,
	input  wire logic [31:0]            regRdata,
	input  wire logic                   regRdOk
);

	logic awHeld;
	logic wHeld;
	logic awTake;
	logic wTake;
	logic arTake;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign awTake        = s_axi_awvalid && s_axi_awready;
	assign wTake         = s_axi_wvalid && s_axi_wready;
	assign arTake        = s_axi_arvalid && s_axi_arready;
	assign regWrite      = awHeld && wHeld && !s_axi_bvalid;
	assign regRaddr      = s_axi_araddr;

	// ============================================================
	// write address and data, taken in either order
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			awHeld     <= 1'b0;
			wHeld      <= 1'b0;
			regWr      <= '0;
		end else begin
			if (awTake) begin
				awHeld     <= 1'b1;
				regWr.addr <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld      <= 1'b1;
				regWr.data <= s_axi_wdata;
				regWr.strb <= s_axi_wstrb;
			end
			if (regWrite) begin
				awHeld     <= 1'b0;
				wHeld      <= 1'b0;
			end
		end
	end

	// ============================================================
	// write response
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CMS_RESP_OKAY;
		end else if (regWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= regWrOk ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ============================================================
	// read data, one cycle after the address is taken
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `CMS_RESP_OKAY;
		end else if (arTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= regRdata;
			s_axi_rresp  <= regRdOk ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // cms_axil_slave

// [rtl/cms_status_mapper.sv]
// configuration status mapper: packs per-function status onto one vector
// assumes field inputs come from logic on core_clk; axi4-lite registers
module cms_status_mapper
	import cms_pkg::*;
(
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	// axi4-lite register bus
	input  wire logic [`CMS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output      logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output      logic                   s_axi_wready,
	output      logic [1:0]             s_axi_bresp,
	output      logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`CMS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output      logic                   s_axi_arready,
	output      logic [31:0]            s_axi_rdata,
	output      logic [1:0]             s_axi_rresp,
	output      logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// configuration space fields
	input  wire cms_func0_t             funcZero,
	input  wire cms_funcn_t [7:1]       funcOther,
	// toward application logic
	output      logic [`CMS_VEC_W-1:0]  config_status_vector,
	output      logic                   status_update_strobe,
	// interrupt
	output      logic                   irq
);

	// ============================================================
	// helpers
	function automatic logic [`CMS_FN_W-1:0] packSlice(cms_funcn_t f);
		packSlice = {f.devStatus, f.linkStatusHigh, f.masterParityErr};
	endfunction

	function automatic logic [31:0] applyStrobe(
		logic [31:0] oldVal,
		logic [31:0] newVal,
		logic [3:0]  strb
	);
		logic [31:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = newVal[b*8 +: 8];
			end
		end
		applyStrobe = res;
	endfunction

	// ============================================================
	// function 0 field wiring
	logic [`CMS_F0_W-1:0]  zeroSlice;
	logic [15:0]           linkField;
	logic [5:0]            linkWidth;
	logic [3:0]            linkSpeed;
	logic [4:0]            linkHigh;
	logic [`CMS_VEC_W-1:0] packed_vec;

	assign linkHigh  = funcZero.linkStatus[15:11];
	assign linkWidth = funcZero.linkStatus[9:4];
	assign linkSpeed = funcZero.linkStatus[3:0];
	assign linkField = {linkHigh, 1'b0, linkWidth, linkSpeed};

	assign zeroSlice[`CMS_F0_DEV_MSB:`CMS_F0_DEV_LSB] =
		funcZero.devStatus;
	assign zeroSlice[`CMS_F0_DLL_BIT] =
		funcZero.dllStateChanged;
	assign zeroSlice[`CMS_F0_CMD_BIT] =
		funcZero.cmdCompleted;
	assign zeroSlice[`CMS_F0_LINK_MSB:`CMS_F0_LINK_LSB] =
		linkField;
	assign zeroSlice[`CMS_F0_DEEMP_BIT] =
		funcZero.deEmphasis;
	assign zeroSlice[`CMS_F0_PRI_MSB:`CMS_F0_PRI_LSB] =
		funcZero.primaryErr;
	assign zeroSlice[`CMS_F0_MPE_BIT] =
		funcZero.masterParityErr;
	assign zeroSlice[`CMS_F0_ROOT_MSB:`CMS_F0_ROOT_LSB] =
		funcZero.rootStatus;
	assign zeroSlice[`CMS_F0_SEC_MSB:`CMS_F0_SEC_LSB] =
		funcZero.secondaryErr;
	assign zeroSlice[`CMS_F0_MPE2_BIT] =
		funcZero.masterParityErr;

	// ============================================================
	// full vector: function 0 low, then one slice per function
	assign packed_vec[`CMS_F0_W-1:0] = zeroSlice;

	for (genvar g = 1; g <= `CMS_FN_COUNT; g++) begin : gSlice
		// slice layout: device status, link high, parity error
		assign packed_vec[`CMS_FN_BASE + (g-1)*`CMS_FN_W +: `CMS_FN_W] =
			packSlice(funcOther[g]);
	end

	// ============================================================
	// update pacing
	logic [`CMS_CNT_W-1:0] paceCount;
	logic                  paceTick;
	logic                  vecDiffers;
	logic                  doUpdate;
	logic                  updEnable;

	assign paceTick   = (paceCount == `CMS_CNT_W'(`CMS_UPDATE_PERIOD - 1));
	assign vecDiffers = (packed_vec != config_status_vector);
	assign doUpdate   = paceTick && vecDiffers && updEnable;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			paceCount <= '0;
		end else begin
			paceCount <= paceCount + `CMS_CNT_W'(1);
		end
	end

	// ============================================================
	// status vector and strobe
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			config_status_vector <= '0;
			status_update_strobe <= 1'b0;
		end else if (doUpdate) begin
			config_status_vector <= packed_vec;
			status_update_strobe <= !status_update_strobe;
		end
	end

	// ============================================================
	// events seen on each applied update
	logic [3:0]            oldDevErr;
	logic [3:0]            newDevErr;
	logic                  errRise;
	logic                  dllRise;
	logic [`CMS_IRQ_W-1:0] events;

	assign oldDevErr = config_status_vector[`CMS_F0_DEV_MSB:`CMS_F0_DEV_LSB];
	assign newDevErr = packed_vec[`CMS_F0_DEV_MSB:`CMS_F0_DEV_LSB];
	assign errRise   = doUpdate && |(newDevErr & ~oldDevErr);
	assign dllRise   = doUpdate && packed_vec[`CMS_F0_DLL_BIT] &&
		!config_status_vector[`CMS_F0_DLL_BIT];
	assign events    = {dllRise, errRise, doUpdate};

	// ============================================================
	// register bus front end
	logic                   regWrite;
	cms_regwr_t             regWr;
	logic                   regWrOk;
	logic [`CMS_ADDR_W-1:0] regRaddr;
	logic [31:0]            regRdata;
	logic                   regRdOk;

	cms_axil_slave u_slave (
		.core_clk      (core_clk),
		.reset         (reset),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.regWrite      (regWrite),
		.regWr         (regWr),
		.regWrOk       (regWrOk),
		.regRaddr      (regRaddr),
		.regRdata      (regRdata),
		.regRdOk       (regRdOk)
	);

	// ============================================================
	// write decode
	logic [31:0] ctrlReg;
	logic [`CMS_IRQ_W-1:0] intStatus;
	logic [`CMS_IRQ_W-1:0] intMask;
	logic [15:0] updCount;
	logic [31:0] wrMerged;
	logic [31:0] ctrlMerged;
	logic        wrCtrl;
	logic        wrIsr;
	logic        wrImr;
	logic        wrReadOnly;
	logic        clearCount;
	logic [`CMS_IRQ_W-1:0] isrClear;
	logic [`CMS_IRQ_W-1:0] next_intStatus;

	assign wrMerged   = applyStrobe(32'h0000_0000, regWr.data, regWr.strb);
	assign ctrlMerged = applyStrobe(ctrlReg, regWr.data, regWr.strb);
	assign wrCtrl     = regWrite && (regWr.addr == `CMS_CTRL_OFS);
	assign wrIsr      = regWrite && (regWr.addr == `CMS_ISR_OFS);
	assign wrImr      = regWrite && (regWr.addr == `CMS_IMR_OFS);
	assign wrReadOnly = (regWr.addr == `CMS_STAT_OFS) ||
		(regWr.addr == `CMS_VEC0_OFS) || (regWr.addr == `CMS_VEC1_OFS) ||
		(regWr.addr == `CMS_VEC2_OFS) || (regWr.addr == `CMS_VEC3_OFS);
	assign regWrOk    = (regWr.addr == `CMS_CTRL_OFS) ||
		(regWr.addr == `CMS_ISR_OFS) || (regWr.addr == `CMS_IMR_OFS) ||
		wrReadOnly;
	assign updEnable  = ctrlReg[`CMS_CTRL_EN_BIT];
	assign clearCount = wrCtrl && ctrlMerged[`CMS_CTRL_CLR_BIT];
	assign isrClear   = wrIsr ? wrMerged[`CMS_IRQ_W-1:0] : '0;
	// a new event wins over a clear in the same cycle
	assign next_intStatus = (intStatus & ~isrClear) | events;

	// ============================================================
	// control, interrupt and counter registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrlReg <= `CMS_CTRL_RST;
		end else if (wrCtrl) begin
			ctrlReg <= {30'h0, 1'b0, ctrlMerged[`CMS_CTRL_EN_BIT]};
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			intStatus <= '0;
			intMask   <= `CMS_IMR_RST;
		end else begin
			intStatus <= next_intStatus;
			if (wrImr) begin
				intMask <= wrMerged[`CMS_IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			updCount <= '0;
		end else if (clearCount) begin
			updCount <= '0;
		end else if (doUpdate) begin
			updCount <= updCount + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_intStatus & intMask);
		end
	end

	// ============================================================
	// read decode
	logic [31:0] statWord;
	logic [127:0] vecWide;

	assign statWord = {updCount, 5'h00, paceCount, 7'h00,
		status_update_strobe};
	assign vecWide  = {5'h00, config_status_vector};

	always_comb begin
		regRdOk  = 1'b1;
		regRdata = 32'h0000_0000;
		case (regRaddr)
			`CMS_CTRL_OFS: regRdata = ctrlReg;
			`CMS_STAT_OFS: regRdata = statWord;
			`CMS_ISR_OFS:  regRdata = {29'h0, intStatus};
			`CMS_IMR_OFS:  regRdata = {29'h0, intMask};
			`CMS_VEC0_OFS: regRdata = vecWide[31:0];
			`CMS_VEC1_OFS: regRdata = vecWide[63:32];
			`CMS_VEC2_OFS: regRdata = vecWide[95:64];
			`CMS_VEC3_OFS: regRdata = vecWide[127:96];
			default:       regRdOk  = 1'b0;
		endcase
	end

endmodule // cms_status_mapper

// [tb/cms_app_model.sv]
// application side model: takes the status vector after each strobe edge
// assumes vector and strobe come from the mapper on the same clock
module cms_app_model
(
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	// from the mapper
	input  wire logic [`CMS_VEC_W-1:0] statusVec,
	input  wire logic                  statusStrobe,
	// captured view
	output      logic [`CMS_VEC_W-1:0] seenVec
);
	timeunit 1ns;
	timeprecision 1ps;

	logic lastStrobe;

	// ============================================================
	// sample one edge after the toggle, where the vector is settled
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lastStrobe <= 1'b0;
			seenVec    <= '0;
		end else begin
			lastStrobe <= statusStrobe;
			if (statusStrobe != lastStrobe) seenVec <= statusVec;
		end
	end
endmodule // cms_app_model

// [tb/cms_map_chk.sv]
// checker of the status vector layout and of the strobe pacing
// assumes a bind to cms_status_mapper, one clock, async active-high reset
module cms_map_chk
	import cms_pkg::*;
(
	// clock and reset
	input wire logic                  core_clk,
	input wire logic                  reset,
	// watched ports
	input wire cms_func0_t            funcZero,
	input wire cms_funcn_t [7:1]      funcOther,
	input wire logic [`CMS_VEC_W-1:0] config_status_vector,
	input wire logic                  status_update_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] paceCnt;

	// ============================================================
	// cycles since reset, modulo the update period
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) paceCnt <= 3'h0;
		else paceCnt <= paceCnt + 3'h1;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence stbToggle;
		$changed(status_update_strobe);
	endsequence

	// ============================================================
	// assertions
	pace_grid_a: assert property (stbToggle |-> paceCnt == 3'h0)
		else $error("strobe toggled off the eight cycle grid");
	vec_strobe_a: assert property ($changed(config_status_vector) |->
		stbToggle) else $error("vector changed without strobe toggle");
	dev_err_map_a: assert property (stbToggle |->
		config_status_vector[52:49] == $past(funcZero.devStatus))
		else $error("function 0 device errors misplaced");
	slot_flags_a: assert property (stbToggle |->
		config_status_vector[48:47] ==
		$past({funcZero.dllStateChanged, funcZero.cmdCompleted}))
		else $error("slot flags misplaced");
	link_map_a: assert property (stbToggle |->
		config_status_vector[46:31] == ($past(funcZero.linkStatus) & 16'hfbff))
		else $error("link status misplaced");
	undef_zero_a: assert property (config_status_vector[41] == 1'b0)
		else $error("undefined link bit not zero");
	pri_map_a: assert property (stbToggle |->
		config_status_vector[30:25] ==
		$past({funcZero.deEmphasis, funcZero.primaryErr}))
		else $error("de-emphasis or primary status misplaced");
	parity_map_a: assert property (stbToggle |->
		config_status_vector[24] == $past(funcZero.masterParityErr) &&
		config_status_vector[0] == $past(funcZero.masterParityErr))
		else $error("parity error bits misplaced");
	root_sec_a: assert property (stbToggle |->
		config_status_vector[23:1] ==
		$past({funcZero.rootStatus, funcZero.secondaryErr}))
		else $error("root or secondary status misplaced");
	for (genvar n = 1; n <= 7; n++) begin : g_slice
		slice_map_a: assert property (stbToggle |->
			config_status_vector[53+(n-1)*10 +: 10] == $past(funcOther[n]))
			else $error("function slice misplaced");
	end
endmodule // cms_map_chk

bind cms_status_mapper cms_map_chk chk (
	.core_clk             (core_clk),
	.reset                (reset),
	.funcZero             (funcZero),
	.funcOther            (funcOther),
	.config_status_vector (config_status_vector),
	.status_update_strobe (status_update_strobe)
);

// [tb/testbench.sv]
// self-checking bench of the configuration status mapper
// assumes package, rtl, application model and checker compiled first
module testbench
	import cms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// signals
	logic             core_clk = 1'b0;
	logic             reset    = 1'b1;
	logic [7:0]       awAddr   = 8'h00;
	logic [7:0]       arAddr   = 8'h00;
	logic [31:0]      wData    = 32'h0;
	logic             awValid  = 1'b0;
	logic             wValid   = 1'b0;
	logic             bReady   = 1'b0;
	logic             arValid  = 1'b0;
	logic             rReady   = 1'b0;
	cms_func0_t       fz       = '0;
	cms_funcn_t [7:1] fo       = '0;
	wire logic        awReady, wReady, bValid, arReady, rValid, irq, stb;
	wire logic [1:0]  bResp, rResp;
	wire logic [31:0] rData;
	wire logic [122:0] vec, seenVec;
	int               nFail    = 0;
	int               nTests   = 0;
	logic [121:0]     pats [3] = '{'1, {61{2'b10}}, {61{2'b01}}};

	always #4 core_clk = ~core_clk;

	cms_status_mapper uut (
		.core_clk(core_clk), .reset(reset),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.funcZero(fz), .funcOther(fo), .config_status_vector(vec),
		.status_update_strobe(stb), .irq(irq)
	);

	cms_app_model app (
		.core_clk(core_clk), .reset(reset), .statusVec(vec),
		.statusStrobe(stb), .seenVec(seenVec)
	);

	// ============================================================
	// compares and expectation
	task automatic checkVec(input logic [122:0] got, exp, input string m);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic checkWord(input logic [31:0] got, exp, input string m);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	// link bit 10 of function 0 reads zero, parity error repeats at bit 0
	function automatic logic [122:0] expVec(input logic [121:0] p);
		return {p[121:41], 1'b0, p[39:0], p[23]};
	endfunction

	// ============================================================
	// axi4-lite master: tasks start and end just after a rising edge
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w, ha, hw, hb;
		aw = 1'b0;
		w = 1'b0;
		hb = 1'b0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		while (!(aw && w)) begin
			@(negedge core_clk);
			ha = awValid && awReady;
			hw = wValid && wReady;
			@(posedge core_clk);
			if (ha) awValid <= 1'b0;
			if (hw) wValid <= 1'b0;
			aw = aw | ha;
			w = w | hw;
		end
		bReady <= 1'b1;
		while (!hb) begin
			@(negedge core_clk);
			hb = bValid;
			r = bResp;
			@(posedge core_clk);
		end
		bReady <= 1'b0;
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic h;
		h = 1'b0;
		arAddr <= a;
		arValid <= 1'b1;
		while (!h) begin
			@(negedge core_clk);
			h = arReady;
			@(posedge core_clk);
		end
		arValid <= 1'b0;
		rReady <= 1'b1;
		h = 1'b0;
		while (!h) begin
			@(negedge core_clk);
			h = rValid;
			d = rData;
			r = rResp;
			@(posedge core_clk);
		end
		rReady <= 1'b0;
	endtask

	task automatic regIs(input logic [7:0] a, input logic [31:0] e,
		input string m);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		checkWord(d, e, m);
		checkWord({30'h0, r}, {30'h0, `CMS_RESP_OKAY}, m);
	endtask

	// waits for the strobe to leave level s, bounded by five update periods
	task automatic waitUpd(input logic s);
		int t;
		t = 0;
		do begin
			@(negedge core_clk);
			t++;
		end while (stb === s && t < 40);
		checkWord({31'h0, stb}, {31'h0, ~s}, "strobe toggle");
		@(posedge core_clk);
	endtask

	task automatic update(input logic [121:0] p);
		{fo, fz} <= p;
		waitUpd(stb);
		checkVec(vec, expVec(p), "status vector");
	endtask

	task automatic endOfTest();
		$display("comparisons %0d, mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin : watchdog
		#200us;
		nFail++;
		endOfTest();
	end

	// ============================================================
	// tests
	initial begin : main
		logic [127:0] e;
		logic [31:0] d;
		logic [1:0] r;
		logic s;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		checkVec(vec, '0, "reset vector");
		@(posedge core_clk);
		regIs(`CMS_CTRL_OFS, 32'h1, "control reset");
		regIs(`CMS_IMR_OFS, 32'h0, "mask reset");
		$display("test reset done");
		foreach (pats[i]) update(pats[i]);
		for (int b = 0; b < 122; b++) update(122'h1 << b);
		@(posedge core_clk);
		checkVec(seenVec, expVec(122'h1 << 121), "application view");
		e = {5'h0, expVec(122'h1 << 121)};
		for (int k = 0; k < 4; k++)
			regIs(`CMS_VEC0_OFS + 8'(4 * k), e[32*k +: 32], "vector word");
		$display("test mapping done");
		axiWrite(`CMS_CTRL_OFS, 32'h0, r);
		{fo, fz} <= '0;
		repeat (24) @(posedge core_clk);
		checkVec(vec, expVec(122'h1 << 121), "frozen vector");
		// the update may already land while the write completes
		s = stb;
		axiWrite(`CMS_CTRL_OFS, 32'h1, r);
		waitUpd(s);
		checkVec(vec, '0, "resumed vector");
		s = stb;
		repeat (24) @(posedge core_clk);
		checkWord({31'h0, stb}, {31'h0, s}, "idle strobe");
		$display("test enable done");
		axiWrite(`CMS_ISR_OFS, 32'h7, r);
		regIs(`CMS_ISR_OFS, 32'h0, "status cleared");
		axiWrite(`CMS_IMR_OFS, 32'h7, r);
		checkWord({31'h0, irq}, 32'h0, "irq idle");
		update(122'h3 << 47);
		@(negedge core_clk);
		checkWord({31'h0, irq}, 32'h1, "irq raised");
		@(posedge core_clk);
		regIs(`CMS_ISR_OFS, 32'h7, "status events");
		axiWrite(`CMS_IMR_OFS, 32'h0, r);
		@(negedge core_clk);
		checkWord({31'h0, irq}, 32'h0, "irq masked");
		@(posedge core_clk);
		axiWrite(`CMS_ISR_OFS, 32'h7, r);
		regIs(`CMS_ISR_OFS, 32'h0, "status cleared again");
		$display("test interrupt done");
		axiWrite(8'h40, 32'h1, r);
		checkWord({30'h0, r}, {30'h0, `CMS_RESP_SLVERR}, "unmapped write");
		axiRead(8'h40, d, r);
		checkWord({30'h0, r}, {30'h0, `CMS_RESP_SLVERR}, "unmapped read");
		// 3 patterns, 122 one-hot steps, resume and interrupt: 127 updates
		axiRead(`CMS_STAT_OFS, d, r);
		checkWord(d & 32'hffff_f8ff, {16'h007f, 15'h0, stb}, "update count");
		axiWrite(`CMS_CTRL_OFS, 32'h3, r);
		regIs(`CMS_CTRL_OFS, 32'h1, "control self clear");
		axiRead(`CMS_STAT_OFS, d, r);
		checkWord(d & 32'hffff_f8ff, {31'h0, stb}, "count cleared");
		axiWrite(`CMS_STAT_OFS, 32'hffff_ffff, r);
		checkWord({30'h0, r}, {30'h0, `CMS_RESP_OKAY}, "status write");
		$display("test bus errors done");
		endOfTest();
	end
endmodule // testbench
